// File: hdl/trv_consts.svh
`ifndef TRV_CONSTS_SVH
`define TRV_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TRV_ADDR_W        8
`define TRV_OFS_CTRL      8'h00
`define TRV_OFS_STATUS    8'h10
`define TRV_OFS_MODE12    8'h18
`define TRV_OFS_MODE34    8'h1C
`define TRV_OFS_ENABLE    8'h20
`define TRV_OFS_COUNTER   8'h24
`define TRV_OFS_RELOAD    8'h2C
`define TRV_OFS_CHAN1     8'h34
`define TRV_OFS_CHAN2     8'h38
`define TRV_OFS_CHAN3     8'h3C
`define TRV_OFS_CHAN4     8'h40

// ****************************************
// Field positions
// ****************************************
`define TRV_CTRL_COUNT_EN   0
`define TRV_CTRL_RELOAD_PRE 7
`define TRV_MODE_HI_SHIFT   8
`define TRV_MODE_PRE        3
`define TRV_ENABLE_STRIDE   4
`define TRV_STATUS_RUN      0
`define TRV_STATUS_REF      4
`define TRV_STATUS_INPUT    8

// ****************************************
// Reset values and masks
// ****************************************
`define TRV_RST_RELOAD    32'hFFFFFFFF
`define TRV_RST_CHAN      32'h00000000
`define TRV_NARROW_MASK   32'h0000FFFF

`endif

// File: hdl/trv_pkg.sv
`include "trv_consts.svh"

package trv_pkg;

  typedef enum logic [1:0] {
    TRV_DIR_OUT  = 2'b00,
    TRV_DIR_OWN  = 2'b01,
    TRV_DIR_PAIR = 2'b10,
    TRV_DIR_TRIG = 2'b11
  } trv_dir_t;

  typedef enum logic [1:0] {
    TRV_APB_IDLE = 2'b01,
    TRV_APB_DONE = 2'b10
  } trv_apb_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [31:0] wdata;
  } trv_bus_req_t;

  typedef struct packed {
    trv_dir_t dir;
    logic     preload;
    logic     cap_en;
  } trv_chan_cfg_t;

  typedef struct packed {
    logic own;
    logic pair;
    logic trig;
  } trv_cap_src_t;

  // Narrow instances keep only the low half
  function automatic logic [31:0] trv_fit(input logic [31:0] v, input logic wide);
    trv_fit = wide ? v : (v & `TRV_NARROW_MASK);
  endfunction

  function automatic logic trv_is_input(input trv_dir_t d);
    trv_is_input = (d != TRV_DIR_OUT);
  endfunction

endpackage

// File: hdl/trv_apb_slave.sv
`timescale 1ns/1ps
`include "trv_consts.svh"

module trv_apb_slave (
  // Clock and reset
  input  logic                clock,
  input  logic                reset_n,
  // APB
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [7:0]          paddr,
  input  logic [31:0]         pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // Register side
  output trv_pkg::trv_bus_req_t req,
  output logic                wr_commit,
  input  logic [31:0]         rd_data,
  input  logic                addr_hit
);

  trv_pkg::trv_apb_state_t state_ff;
  trv_pkg::trv_apb_state_t nxt_state;
  logic [31:0]             prdata_ff;
  logic                    hit_ff;
  wire                     access = psel & penable;
  wire                     fetch  = access & (state_ff == trv_pkg::TRV_APB_IDLE);

  assign req       = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign pready    = access & (state_ff == trv_pkg::TRV_APB_DONE);
  assign pslverr   = pready & ~hit_ff;
  assign wr_commit = pready & pwrite & hit_ff;
  assign prdata    = prdata_ff;
  assign nxt_state = fetch ? trv_pkg::TRV_APB_DONE : trv_pkg::TRV_APB_IDLE;

  // One wait state lets read data leave a flip-flop
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_ff  <= trv_pkg::TRV_APB_IDLE;
      prdata_ff <= 32'h00000000;
      hit_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (fetch) begin
        prdata_ff <= (addr_hit && !pwrite) ? rd_data : 32'h00000000;
        hit_ff    <= addr_hit;
      end
    end
  end

endmodule

// File: hdl/trv_channel.sv
`timescale 1ns/1ps
`include "trv_consts.svh"

module trv_channel #(
  parameter bit WIDE = 1'b1
) (
  // Clock and reset
  input  logic                  clock,
  input  logic                  reset_n,
  // Configuration and events
  input  trv_pkg::trv_chan_cfg_t cfg,
  input  trv_pkg::trv_cap_src_t  cap_src,
  input  logic                  update_event,
  input  logic [31:0]           counter_value,
  // Software write
  input  logic                  wr_strobe,
  input  logic [31:0]           wdata,
  // Results
  output logic [31:0]           value,
  output logic [31:0]           active,
  output logic                  output_ref
);

  logic [31:0] value_ff;
  logic [31:0] active_ff;
  logic        ref_ff;
  logic [31:0] nxt_value;
  wire         is_input = trv_pkg::trv_is_input(cfg.dir);
  wire         sel_evt  = (cfg.dir == trv_pkg::TRV_DIR_OWN)  ? cap_src.own  :
                          (cfg.dir == trv_pkg::TRV_DIR_PAIR) ? cap_src.pair :
                          (cfg.dir == trv_pkg::TRV_DIR_TRIG) ? cap_src.trig : 1'b0;
  wire         cap_take = is_input & cfg.cap_en & sel_evt;
  wire         wr_take  = wr_strobe & ~is_input;

  assign nxt_value  = cap_take ? trv_pkg::trv_fit(counter_value, WIDE) :
                      wr_take  ? trv_pkg::trv_fit(wdata, WIDE) : value_ff;
  assign value      = value_ff;
  assign active     = active_ff;
  assign output_ref = ref_ff;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      value_ff  <= `TRV_RST_CHAN;
      active_ff <= `TRV_RST_CHAN;
      ref_ff    <= 1'b0;
    end else begin
      value_ff <= nxt_value;
      if (!is_input && !cfg.preload) begin
        active_ff <= nxt_value;
      end else if (!is_input && update_event) begin
        active_ff <= value_ff;
      end
      ref_ff <= ~is_input & (trv_pkg::trv_fit(counter_value, WIDE) < active_ff);
    end
  end

endmodule

// File: hdl/trv_top.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "trv_consts.svh"

// Summary of operation
// - Written reload value feeds active reload
// - Counter held while reload value is zero
// - Upper halves exist only on wide instances
// - Preload off: compare write goes active immediately
// - Preload on: compare moves at update event
// - Active compare versus counter drives output reference
// - Input mode captures counter at capture event
// - Input mode ignores software compare writes
// - Direction field picks compare or capture behaviour
// - Direction 00 output; 01 own, 10 pair, 11 trigger
// - Capture happens only with capture enable set
module trv_top #(
  parameter bit WIDE_TIMER = 1'b1
) (
  // Clock and reset
  input  logic        clock,
  input  logic        reset_n,
  // APB
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Timer core
  input  logic [31:0] counter_value,
  input  logic        update_event,
  input  logic [3:0]  chan_capture_event,
  input  logic        trigger_capture_event,
  output logic [31:0] reload_value,
  output logic        count_enable,
  // Channel results
  output logic [3:0]  chan_output_ref,
  output logic [3:0]  chan_is_input
);

  // ****************************************
  // Declarations
  // ****************************************
  trv_pkg::trv_bus_req_t  req;
  trv_pkg::trv_chan_cfg_t chan_cfg     [4];
  trv_pkg::trv_cap_src_t  chan_src     [4];
  trv_pkg::trv_dir_t      dir_ff       [4];
  trv_pkg::trv_dir_t      nxt_dir      [4];
  logic [3:0]             preload_ff;
  logic [3:0]             nxt_preload;
  logic [3:0]             cap_en_ff;
  logic [3:0]             nxt_cap_en;
  logic [31:0]            chan_value   [4];
  logic [31:0]            chan_active  [4];
  logic [3:0]             chan_wr;
  logic [3:0]             chan_ref;
  logic                   wr_commit;
  logic [31:0]            rd_data;
  logic                   addr_hit;
  logic                   count_en_ff;
  logic                   reload_pre_en_ff;
  logic [31:0]            reload_pre_ff;
  logic [31:0]            reload_act_ff;
  logic [31:0]            nxt_reload_pre;
  logic [31:0]            mode12_rd;
  logic [31:0]            mode34_rd;
  logic [31:0]            enable_rd;
  logic [31:0]            ctrl_rd;
  logic [31:0]            status_rd;
  logic                   run_ff;

  // ****************************************
  // Bus slave
  // ****************************************
  trv_apb_slave u_apb (
    .clock     (clock),
    .reset_n   (reset_n),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .req       (req),
    .wr_commit (wr_commit),
    .rd_data   (rd_data),
    .addr_hit  (addr_hit)
  );

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_ctrl    = (req.addr == `TRV_OFS_CTRL);
  wire hit_status  = (req.addr == `TRV_OFS_STATUS);
  wire hit_mode12  = (req.addr == `TRV_OFS_MODE12);
  wire hit_mode34  = (req.addr == `TRV_OFS_MODE34);
  wire hit_enable  = (req.addr == `TRV_OFS_ENABLE);
  wire hit_counter = (req.addr == `TRV_OFS_COUNTER);
  wire hit_reload  = (req.addr == `TRV_OFS_RELOAD);
  wire hit_chan1   = (req.addr == `TRV_OFS_CHAN1);
  wire hit_chan2   = (req.addr == `TRV_OFS_CHAN2);
  wire hit_chan3   = (req.addr == `TRV_OFS_CHAN3);
  wire hit_chan4   = (req.addr == `TRV_OFS_CHAN4);

  assign addr_hit = hit_ctrl | hit_status | hit_mode12 | hit_mode34 | hit_enable |
                    hit_counter | hit_reload | hit_chan1 | hit_chan2 | hit_chan3 | hit_chan4;

  wire wr_ctrl   = wr_commit & hit_ctrl;
  wire wr_mode12 = wr_commit & hit_mode12;
  wire wr_mode34 = wr_commit & hit_mode34;
  wire wr_enable = wr_commit & hit_enable;
  wire wr_reload = wr_commit & hit_reload;

  assign chan_wr = {wr_commit & hit_chan4, wr_commit & hit_chan3,
                    wr_commit & hit_chan2, wr_commit & hit_chan1};

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_en_ff      <= 1'b0;
      reload_pre_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
      count_en_ff      <= req.wdata[`TRV_CTRL_COUNT_EN];
      reload_pre_en_ff <= req.wdata[`TRV_CTRL_RELOAD_PRE];
    end
  end

  assign ctrl_rd = {24'h000000, reload_pre_en_ff, 6'h00, count_en_ff};

  // ****************************************
  // Channel mode and enable registers
  // ****************************************
  // A live channel keeps its direction, so a capture source never flips mid-use
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mode
      localparam int BASE = (gi % 2) * `TRV_MODE_HI_SHIFT;
      wire wr_mode = (gi < 2) ? wr_mode12 : wr_mode34;

      assign nxt_cap_en[gi]  = wr_enable ? req.wdata[gi * `TRV_ENABLE_STRIDE] : cap_en_ff[gi];
      assign nxt_preload[gi] = wr_mode ? req.wdata[BASE + `TRV_MODE_PRE] : preload_ff[gi];
      assign nxt_dir[gi]     = (wr_mode && !cap_en_ff[gi]) ?
                               trv_pkg::trv_dir_t'(req.wdata[BASE +: 2]) : dir_ff[gi];

      always_ff @(posedge clock) begin
        if (!reset_n) begin
          dir_ff[gi]     <= trv_pkg::TRV_DIR_OUT;
          preload_ff[gi] <= 1'b0;
          cap_en_ff[gi]  <= 1'b0;
        end else begin
          dir_ff[gi]     <= nxt_dir[gi];
          preload_ff[gi] <= nxt_preload[gi];
          cap_en_ff[gi]  <= nxt_cap_en[gi];
        end
      end

      assign chan_cfg[gi] = '{dir: dir_ff[gi], preload: preload_ff[gi], cap_en: cap_en_ff[gi]};
      assign chan_src[gi] = '{own:  chan_capture_event[gi],
                              pair: chan_capture_event[gi ^ 1],
                              trig: trigger_capture_event};
      assign chan_is_input[gi] = trv_pkg::trv_is_input(dir_ff[gi]);
    end
  endgenerate

  assign mode12_rd = {16'h0000, 4'h0, preload_ff[1], 1'b0, dir_ff[1],
                      4'h0, preload_ff[0], 1'b0, dir_ff[0]};
  assign mode34_rd = {16'h0000, 4'h0, preload_ff[3], 1'b0, dir_ff[3],
                      4'h0, preload_ff[2], 1'b0, dir_ff[2]};
  assign enable_rd = {16'h0000, 3'h0, cap_en_ff[3], 3'h0, cap_en_ff[2],
                      3'h0, cap_en_ff[1], 3'h0, cap_en_ff[0]};

  // ****************************************
  // Reload value
  // ****************************************
  assign nxt_reload_pre = wr_reload ? trv_pkg::trv_fit(req.wdata, WIDE_TIMER) : reload_pre_ff;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reload_pre_ff <= trv_pkg::trv_fit(`TRV_RST_RELOAD, WIDE_TIMER);
      reload_act_ff <= trv_pkg::trv_fit(`TRV_RST_RELOAD, WIDE_TIMER);
    end else begin
      reload_pre_ff <= nxt_reload_pre;
      if (!reload_pre_en_ff) begin
        reload_act_ff <= nxt_reload_pre;
      end else if (update_event) begin
        reload_act_ff <= reload_pre_ff;
      end
    end
  end

  // Run gate is registered; the direct nonzero-reload term still stops the counter in the cycle a zero reload goes active
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= count_en_ff & (reload_act_ff != 32'h00000000);
    end
  end

  assign reload_value = reload_act_ff;
  assign count_enable = run_ff & (reload_act_ff != 32'h00000000);

  // ****************************************
  // Channels
  // ****************************************
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      trv_channel #(
        .WIDE (WIDE_TIMER)
      ) u_chan (
        .clock         (clock),
        .reset_n       (reset_n),
        .cfg           (chan_cfg[gi]),
        .cap_src       (chan_src[gi]),
        .update_event  (update_event),
        .counter_value (counter_value),
        .wr_strobe     (chan_wr[gi]),
        .wdata         (req.wdata),
        .value         (chan_value[gi]),
        .active        (chan_active[gi]),
        .output_ref    (chan_ref[gi])
      );
    end
  endgenerate

  assign chan_output_ref = chan_ref;

  // ****************************************
  // Status and read back
  // ****************************************
  assign status_rd = {20'h00000, chan_is_input, chan_ref, 3'h0, count_enable};

  assign rd_data = hit_ctrl    ? ctrl_rd :
                   hit_status  ? status_rd :
                   hit_mode12  ? mode12_rd :
                   hit_mode34  ? mode34_rd :
                   hit_enable  ? enable_rd :
                   hit_counter ? trv_pkg::trv_fit(counter_value, WIDE_TIMER) :
                   hit_reload  ? reload_pre_ff :
                   hit_chan1   ? chan_value[0] :
                   hit_chan2   ? chan_value[1] :
                   hit_chan3   ? chan_value[2] :
                   hit_chan4   ? chan_value[3] : 32'h00000000;

endmodule

// File: bench/trv_top_checker.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for trv_top
// ****************************************
module trv_top_checker #(
  parameter bit WIDE_TIMER = 1'b1
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timer core
  input wire logic [31:0] counter_value,
  input wire logic        update_event,
  input wire logic [3:0]  chan_capture_event,
  input wire logic        trigger_capture_event,
  input wire logic [31:0] reload_value,
  input wire logic        count_enable,
  input wire logic [3:0]  chan_output_ref,
  input wire logic [3:0]  chan_is_input
);
  wire reload_wr = psel && penable && pready && pwrite && (paddr == 8'h2C);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_error_data: assert property (pslverr && !pwrite |-> pready && prdata == 32'h00000000)
    else $error("error read without zero data");
  chk_reload_block: assert property (reload_value == 32'h00000000 |-> !count_enable)
    else $error("count enabled with zero reload");
  chk_narrow_upper: assert property (!WIDE_TIMER |-> reload_value[31:16] == 16'h0000)
    else $error("narrow reload upper half set");
  chk_reload_cause: assert property ($changed(reload_value) |->
    $past(reload_wr) || $past(reload_wr, 2) || $past(update_event))
    else $error("reload changed without write or update");
  chk_input_no_ref: assert property ((chan_output_ref & $past(chan_is_input)) == 4'h0)
    else $error("reference high on input channel");
  chk_ref_top_count: assert property ($past(counter_value) == 32'hFFFFFFFF |-> chan_output_ref == 4'h0)
    else $error("reference high at full count");

  cover property (reload_wr);
  cover property (pslverr);
  cover property ($rose(count_enable));
  cover property (chan_output_ref != 4'h0);
endmodule

bind trv_top trv_top_checker #(.WIDE_TIMER(WIDE_TIMER)) chk_u (.clock(clock), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .counter_value(counter_value), .update_event(update_event),
  .chan_capture_event(chan_capture_event), .trigger_capture_event(trigger_capture_event),
  .reload_value(reload_value), .count_enable(count_enable), .chan_output_ref(chan_output_ref),
  .chan_is_input(chan_is_input));

// File: bench/trv_top_tb.sv
`timescale 1ns/1ps
module trv_top_tb;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, er;
  logic        update_event, trigger_capture_event, count_enable;
  logic [7:0]  paddr;
  logic [31:0] pwdata, counter_value, prdata, reload_value, reload_n, rd, v, m_val;
  logic [3:0]  chan_capture_event, chan_output_ref, chan_is_input;
  logic [31:0] m_act [4];
  bit          m_in [4];
  logic [5:0]  ev;
  int          miscompares, compares;

  trv_top #(.WIDE_TIMER(1'b1)) dut_u (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_value(counter_value), .update_event(update_event), .chan_capture_event(chan_capture_event),
    .trigger_capture_event(trigger_capture_event), .reload_value(reload_value), .count_enable(count_enable),
    .chan_output_ref(chan_output_ref), .chan_is_input(chan_is_input));
  // Narrow twin shares the bus; only its reload output is compared
  trv_top #(.WIDE_TIMER(1'b0)) dut_n (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .counter_value(counter_value), .update_event(update_event), .chan_capture_event(chan_capture_event),
    .trigger_capture_event(trigger_capture_event), .reload_value(reload_n), .count_enable(),
    .chan_output_ref(), .chan_is_input());

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ready is sampled at the rising edge; only the watchdog ends a wait that never completes
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task settle;
    repeat (3) @(negedge clock);
  endtask

  task fire(input logic [5:0] e);
    @(posedge clock);
    {trigger_capture_event, update_event, chan_capture_event} <= e;
    @(posedge clock);
    {trigger_capture_event, update_event, chan_capture_event} <= 6'h00;
    settle();
  endtask

  task setcnt(input logic [31:0] c);
    @(posedge clock);
    counter_value <= c;
    settle();
    for (int i = 0; i < 4; i++) begin
      chk("output_ref", chan_output_ref[i], !m_in[i] && counter_value < m_act[i]);
    end
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reset_n, psel, penable, pwrite, update_event, trigger_capture_event} = 6'h00;
    {paddr, pwdata, counter_value, chan_capture_event} = '0;
    miscompares = 0;
    compares = 0;
    void'($urandom(78142));
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("reload_value", reload_value, 32'hFFFFFFFF);
    chk("narrow reload", reload_n, 32'h0000FFFF);
    apb(8'h2C, 1'b0, 32'h0);
    chk("reload reg", rd, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      apb(8'h34 + 8'(4 * i), 1'b0, 32'h0);
      chk("chan reg reset", rd, 32'h00000000);
    end
    apb(8'h44, 1'b0, 32'h0);
    chk("unmapped err", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // Reload without preload, then zero
    apb(8'h00, 1'b1, 32'h1);
    v = $urandom | 32'h1;
    apb(8'h2C, 1'b1, v);
    settle();
    chk("reload_value", reload_value, v);
    chk("narrow reload", reload_n, v & 32'h0000FFFF);
    chk("count_enable", count_enable, 32'h1);
    apb(8'h2C, 1'b1, 32'h0);
    settle();
    chk("count_enable", count_enable, 32'h0);
    // Reload with preload waits for update
    apb(8'h00, 1'b1, 32'h81);
    apb(8'h2C, 1'b1, v);
    settle();
    chk("reload_value", reload_value, 32'h0);
    fire(6'h10);
    chk("reload_value", reload_value, v);
    chk("count_enable", count_enable, 32'h1);
    // Compare without preload, every channel at its boundary
    for (int i = 0; i < 4; i++) begin
      m_act[i] = ($urandom & 32'h0FFFFFFF) | 32'h00000100;
      apb(8'h34 + 8'(4 * i), 1'b1, m_act[i]);
      apb(8'h34 + 8'(4 * i), 1'b0, 32'h0);
      chk("chan reg", rd, m_act[i]);
    end
    for (int i = 0; i < 4; i++) begin
      setcnt(m_act[i]);
      setcnt(m_act[i] - 32'h1);
    end
    setcnt(32'hFFFFFFFF);
    // Compare with preload on channel 1
    apb(8'h18, 1'b1, 32'h8);
    apb(8'h34, 1'b1, 32'h10);
    setcnt(32'h20);
    fire(6'h10);
    m_act[0] = 32'h10;
    setcnt(32'h0F);
    setcnt(32'h10);
    m_val = 32'h10;
    // Capture from own, paired and trigger sources
    for (int d = 1; d < 4; d++) begin
      ev = (d == 1) ? 6'h01 : (d == 2) ? 6'h02 : 6'h20;
      apb(8'h20, 1'b1, 32'h0);
      apb(8'h18, 1'b1, 32'(d));
      m_in[0] = 1'b1;
      settle();
      chk("chan_is_input", chan_is_input, 32'h1);
      v = $urandom;
      setcnt(v);
      fire(ev);
      apb(8'h34, 1'b0, 32'h0);
      chk("capture disabled", rd, m_val);
      apb(8'h20, 1'b1, 32'h1);
      fire(ev);
      m_val = v;
      apb(8'h34, 1'b0, 32'h0);
      chk("captured", rd, m_val);
      apb(8'h34, 1'b1, ~v);
      apb(8'h34, 1'b0, 32'h0);
      chk("write ignored", rd, m_val);
    end
    conclude();
  end
endmodule
